// [verilog/cso_pkg.sv]
`default_nettype none
package cso_pkg;
    // Core clock
    localparam int CLK_PERIOD_PS      = 4000;
    localparam int PS_PER_MS          = 1_000_000_000;
    // Config clock limits (66.7 MHz ceiling)
    localparam int CCLK_PERIOD_MIN_PS = 15000;
    localparam int CCLK_PHASE_MIN_PS  = 6000;
    // Output-enable timing
    localparam int OE_TO_FIRST_PS     = 40000;
    localparam int HOLD_MARGIN_PS     = 2500;
    localparam int CRC_STOP_MIN_PS    = 277000;
    localparam int EDGE_TO_OE_PS      = 60000;
    localparam int OE_RESET_MIN_PS    = 60000;
    // External clock limits, kept by the clock source
    localparam int EXT_PERIOD_MIN_PS  = 7500;
    localparam int EXT_PHASE_MIN_PS   = 3375;
    // Power-on delays
    localparam int POR_SHORT_MS       = 2;
    localparam int POR_LONG_MS        = 100;

    // Least time to whole cycles, rounded up
    function automatic int cyc_up(input int ps);
        return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    endfunction

    localparam int CCLK_HALF_CYC = (cyc_up(CCLK_PHASE_MIN_PS) > (cyc_up(CCLK_PERIOD_MIN_PS) + 1) / 2) ?
                                   cyc_up(CCLK_PHASE_MIN_PS) : (cyc_up(CCLK_PERIOD_MIN_PS) + 1) / 2;
    localparam int START_CYC     = cyc_up(OE_TO_FIRST_PS);
    localparam int STOP_CYC      = cyc_up(CRC_STOP_MIN_PS);
    localparam int CHECK_CYC     = cyc_up(EDGE_TO_OE_PS);
    localparam int OE_DRIVE_CYC  = cyc_up(OE_RESET_MIN_PS);
    localparam longint POR_SHORT_CYC = longint'(POR_SHORT_MS) * PS_PER_MS / CLK_PERIOD_PS;
    localparam longint POR_LONG_CYC  = longint'(POR_LONG_MS) * PS_PER_MS / CLK_PERIOD_PS;

    // Counter widths
    localparam int TIMER_W = 8;
    localparam int HALF_W  = 4;

    // Synchronised pin indices
    localparam int PIN_N      = 5;
    localparam int PIN_OE     = 0;
    localparam int PIN_DONE   = 1;
    localparam int PIN_EXTCLK = 2;
    localparam int PIN_PORSEL = 3;
    localparam int PIN_USEEXT = 4;

    typedef enum logic [2:0] {
        ST_POR   = 3'b000,
        ST_IDLE  = 3'b001,
        ST_START = 3'b010,
        ST_RUN   = 3'b011,
        ST_CHECK = 3'b100,
        ST_DONE  = 3'b101,
        ST_ERR   = 3'b110
    } cso_state_t;
endpackage
`default_nettype wire

// [verilog/cso_stream_out.sv]
`default_nettype none

module cso_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inVld,
    output logic                  inRdy,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outVld,
    input  wire logic             outRdy,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gBadDepth
            $error("cso_fifo depth must be a power of two, at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    // Honest full and empty from the fill count
    assign inRdy   = (count_q != (AW + 1)'(DEPTH));
    assign outVld  = (count_q != '0);
    assign outData = mem[rdPtr_q];
    assign push    = inVld && inRdy;
    assign pop     = outVld && outRdy;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else if (flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + AW'(push);
            rdPtr_q <= rdPtr_q + AW'(pop);
            count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

module cso_stream_out
    import cso_pkg::*;
#(
    parameter int          WIDTH         = 8,
    parameter int          WORDS         = 256,
    parameter int          FIFO_DEPTH    = 4,
    parameter int unsigned POR_SHORT_CNT = int'(POR_SHORT_CYC),
    parameter int unsigned POR_LONG_CNT  = int'(POR_LONG_CYC)
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Image load port, same clock
    input  wire logic                     imgWrEn,
    input  wire logic [$clog2(WORDS)-1:0] imgWrAddr,
    input  wire logic [WIDTH-1:0]         imgWrData,
    // Pins from outside
    input  wire logic                     oeIn,
    input  wire logic                     fpgaLoadComplete,
    input  wire logic                     externalClockInput,
    input  wire logic                     useExternalClock,
    input  wire logic                     porLongSel,
    // Output-enable pin drive, open drain
    output logic                          oeOut,
    output logic                          oeOutEn,
    // Configuration stream
    output logic                          configClockOut,
    output logic      [WIDTH-1:0]         cfgData,
    output logic                          cfgDataOutEn,
    // Status
    output logic                          loadDone
);
    localparam int AW = $clog2(WORDS);

    generate
        if (WORDS < 2 || WIDTH < 1 || CCLK_HALF_CYC >= (1 << HALF_W)) begin : gBadSize
            $error("cso_stream_out: unsupported size or clock phase");
        end
        if (CCLK_HALF_CYC * CLK_PERIOD_PS < CCLK_PHASE_MIN_PS
            || CCLK_HALF_CYC * CLK_PERIOD_PS < CCLK_HALF_CYC * CLK_PERIOD_PS - HOLD_MARGIN_PS
            || STOP_CYC >= (1 << TIMER_W) || POR_SHORT_CNT < 1 || POR_LONG_CNT < 1) begin : gBadTime
            $error("cso_stream_out: timing constants out of range");
        end
    endgenerate

    logic [WIDTH-1:0]  image [WORDS];
    logic [PIN_N-1:0]  syncA_q;
    logic [PIN_N-1:0]  syncB_q;
    logic [PIN_N-1:0]  syncC_q;
    logic [PIN_N-1:0]  pin_q;
    logic              extPrev_q;
    cso_state_t        state_q;
    logic [31:0]       porCnt_q;
    logic [TIMER_W-1:0] timer_q;
    logic              stopping_q;
    logic [TIMER_W-1:0] stopCnt_q;
    logic [HALF_W-1:0] halfCnt_q;
    logic [AW:0]       rdAddr_q;
    logic [AW:0]       sentCnt_q;
    logic              clk_q;
    logic [WIDTH-1:0]  data_q;
    logic              dataOe_q;
    logic              oeOe_q;
    logic              done_q;
    logic              flush;
    logic              extRise;
    logic              halfDone;
    logic              firstPop;
    logic              doRise;
    logic              doFall;
    logic              lastFall;
    logic              oeLowSeen;
    logic              fifoInVld;
    logic              fifoInRdy;
    logic              fifoOutVld;
    logic [WIDTH-1:0]  fifoOutData;

    // Image memory write port
    always_ff @(posedge clk) begin
        if (imgWrEn) begin
            image[imgWrAddr] <= imgWrData;
        end
    end

    // Three-stage pin synchroniser, change taken when stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA_q   <= '0;
            syncB_q   <= '0;
            syncC_q   <= '0;
            pin_q     <= '0;
            extPrev_q <= 1'b0;
        end else begin
            syncA_q   <= {useExternalClock, porLongSel, externalClockInput, fpgaLoadComplete, oeIn};
            syncB_q   <= syncA_q;
            syncC_q   <= syncB_q;
            for (int i = 0; i < PIN_N; i++) begin
                if (syncB_q[i] == syncC_q[i]) begin
                    pin_q[i] <= syncC_q[i];
                end
            end
            extPrev_q <= pin_q[PIN_EXTCLK];
        end
    end

    // Sequencer decodes
    assign flush     = (state_q == ST_POR) || (state_q == ST_IDLE) || (state_q == ST_ERR);
    assign extRise   = pin_q[PIN_EXTCLK] && !extPrev_q;
    // phase never shorter than the minimum
    assign halfDone  = (halfCnt_q >= HALF_W'(CCLK_HALF_CYC - 1)) && (!pin_q[PIN_USEEXT] || extRise);
    // first word only after the start wait
    assign firstPop  = (state_q == ST_START) && (timer_q >= TIMER_W'(START_CYC - 1)) && fifoOutVld;
    // no late rise that the stop would cut short
    assign doRise    = (state_q == ST_RUN) && halfDone && !clk_q
                       && !(stopping_q && (stopCnt_q >= TIMER_W'(STOP_CYC - CCLK_HALF_CYC - 1)));
    // after the first word, data moves on the falling edge only
    assign doFall    = (state_q == ST_RUN) && halfDone && clk_q && (lastFall || fifoOutVld);
    assign lastFall  = (sentCnt_q == (AW + 1)'(WORDS));
    assign oeLowSeen = !pin_q[PIN_OE] && !oeOe_q && (state_q != ST_POR) && (state_q != ST_IDLE)
                       && (state_q != ST_ERR);
    assign fifoInVld = !flush && (rdAddr_q != (AW + 1)'(WORDS));

    // Word reader feeding the buffer, stalled by its ready
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdAddr_q <= '0;
        end else if (flush) begin
            rdAddr_q <= '0;
        end else if (fifoInVld && fifoInRdy) begin
            rdAddr_q <= rdAddr_q + 1'b1;
        end
    end

    cso_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) uFifo (
        .clk     (clk),
        .rst     (rst),
        .flush   (flush),
        .inVld   (fifoInVld),
        .inRdy   (fifoInRdy),
        .inData  (image[rdAddr_q[AW-1:0]]),
        .outVld  (fifoOutVld),
        .outRdy  (firstPop || (doFall && !lastFall)),
        .outData (fifoOutData)
    );

    // Main state machine and its timers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q  <= ST_POR;
            porCnt_q <= '0;
            timer_q  <= '0;
        end else begin
            timer_q <= (timer_q == '1) ? timer_q : timer_q + 1'b1;
            case (state_q)
                // power-on delay chosen by the strap pin
                ST_POR: begin
                    porCnt_q <= porCnt_q + 1'b1;
                    if (porCnt_q >= (pin_q[PIN_PORSEL] ? POR_LONG_CNT : POR_SHORT_CNT) - 1) begin
                        state_q <= ST_IDLE;
                    end
                end
                // wait for output-enable release, then restart
                ST_IDLE: begin
                    timer_q <= '0;
                    if (pin_q[PIN_OE]) begin
                        state_q <= ST_START;
                    end
                end
                // hold the first edge back after release
                ST_START: begin
                    if (firstPop) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (doFall && lastFall) begin
                        state_q <= ST_CHECK;
                        timer_q <= '0;
                    end
                end
                // spacing after the last falling edge before checking
                ST_CHECK: begin
                    if (timer_q >= TIMER_W'(CHECK_CYC - 1)) begin
                        state_q <= pin_q[PIN_DONE] ? ST_DONE : ST_ERR;
                        timer_q <= '0;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE;
                end
                ST_ERR: begin
                    if (timer_q >= TIMER_W'(OE_DRIVE_CYC - 1)) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_POR;
                end
            endcase
            // outputs go on for the stop delay, then reset
            if (stopping_q && stopCnt_q >= TIMER_W'(STOP_CYC - 1)) begin
                state_q <= ST_IDLE;
            end
        end
    end

    // Output-enable low watch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stopping_q <= 1'b0;
            stopCnt_q  <= '0;
        end else if (stopping_q) begin
            stopCnt_q  <= stopCnt_q + 1'b1;
            stopping_q <= (stopCnt_q < TIMER_W'(STOP_CYC - 1));
        end else begin
            stopCnt_q  <= '0;
            stopping_q <= oeLowSeen;
        end
    end

    // Config clock divider and phase counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halfCnt_q <= '0;
            clk_q     <= 1'b0;
        end else if (state_q != ST_RUN) begin
            halfCnt_q <= '0;
            clk_q     <= 1'b0;
        end else if (doRise || doFall) begin
            halfCnt_q <= '0;
            clk_q     <= doRise;
        end else if (halfCnt_q != '1) begin
            halfCnt_q <= halfCnt_q + 1'b1;
        end
    end

    // Data bus and its enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_q    <= '1;
            dataOe_q  <= 1'b0;
            sentCnt_q <= '0;
        end else begin
            case (state_q)
                ST_START, ST_RUN: begin
                    if (firstPop || (doFall && !lastFall)) begin
                        data_q    <= fifoOutData;
                        dataOe_q  <= 1'b1;
                        sentCnt_q <= sentCnt_q + 1'b1;
                    end
                end
                // all data bits high once finished
                ST_CHECK, ST_DONE: begin
                    data_q   <= '1;
                    dataOe_q <= 1'b1;
                end
                default: begin
                    data_q    <= '1;
                    dataOe_q  <= 1'b0;
                    sentCnt_q <= '0;
                end
            endcase
        end
    end

    // Output-enable pull-low on missing completion, and status
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oeOe_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            // drive only after the check spacing
            oeOe_q <= (state_q == ST_CHECK) && (timer_q >= TIMER_W'(CHECK_CYC - 1)) && !pin_q[PIN_DONE]
                      || (state_q == ST_ERR) && (timer_q < TIMER_W'(OE_DRIVE_CYC - 1));
            done_q <= (state_q == ST_DONE);
        end
    end

    assign oeOut          = 1'b0;
    assign oeOutEn        = oeOe_q;
    assign configClockOut = clk_q;
    assign cfgData        = data_q;
    assign cfgDataOutEn   = dataOe_q;
    assign loadDone       = done_q;
endmodule
`default_nettype wire

// [sim/cso_stream_out_props.sv]
`default_nettype none
module cso_stream_out_props #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             rst,
    // Link pins
    input wire logic             oeIn,
    input wire logic             oeOutEn,
    input wire logic             configClockOut,
    input wire logic [WIDTH-1:0] cfgData,
    input wire logic             cfgDataOutEn,
    input wire logic             loadDone
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] oeHigh_q;
    logic [7:0] farLow_q;
    logic [4:0] riseGap_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Cycles since enable released
    always_ff @(posedge clk or posedge rst) begin
        if (rst) oeHigh_q <= 4'h0;
        else if (!oeIn) oeHigh_q <= 4'h0;
        else if (oeHigh_q != 4'hF) oeHigh_q <= oeHigh_q + 4'h1;
    end

    // Cycles the far side has pulled enable low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) farLow_q <= 8'h00;
        else if (oeIn || oeOutEn) farLow_q <= 8'h00;
        else if (farLow_q != 8'hFF) farLow_q <= farLow_q + 8'h01;
    end

    // Cycles since last rising config clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) riseGap_q <= 5'h00;
        else if ($rose(configClockOut)) riseGap_q <= 5'h00;
        else if (riseGap_q != 5'h1F) riseGap_q <= riseGap_q + 5'h01;
    end

    high_phase_a: assert property ($rose(configClockOut) |=> configClockOut)
        else $error("config clock high phase too short");
    low_phase_a: assert property ($fell(configClockOut) |=> !configClockOut)
        else $error("config clock low phase too short");
    data_hold_a: assert property (configClockOut |-> $stable(cfgData))
        else $error("data changed while config clock high");
    done_rest_a: assert property (loadDone |-> !configClockOut && cfgData == '1)
        else $error("finished state without clock low and data high");
    first_data_a: assert property ($rose(cfgDataOutEn) |-> oeHigh_q >= 4'hA)
        else $error("first data too soon after enable release");
    first_edge_a: assert property ($rose(configClockOut) && oeIn |-> oeHigh_q >= 4'hA)
        else $error("first clock edge too soon after enable release");
    crc_stop_a: assert property ($fell(cfgDataOutEn) && farLow_q != 8'h00 |-> farLow_q >= 8'h46)
        else $error("outputs stopped too soon after enable pulled");
    stop_bound_a: assert property (farLow_q == 8'h5A |-> !cfgDataOutEn && !configClockOut)
        else $error("outputs still running long after enable pulled");
    oe_check_a: assert property ($rose(oeOutEn) |-> riseGap_q >= 5'h0F)
        else $error("enable driven too soon after clock rise");
    oe_pulse_a: assert property ($fell(oeOutEn) |-> $past(oeOutEn, 15) && $past(oeOutEn, 8))
        else $error("enable pull shorter than expected");

    cover property ($rose(loadDone));
    cover property ($rose(oeOutEn));
    cover property ($fell(cfgDataOutEn) && farLow_q != 8'h00);
endmodule

bind cso_stream_out cso_stream_out_props #(.WIDTH(WIDTH)) cso_stream_out_props_i (
    .clk, .rst, .oeIn, .oeOutEn, .configClockOut, .cfgData, .cfgDataOutEn, .loadDone
);
`default_nettype wire

// [sim/cso_far_end.sv]
`default_nettype none
module cso_far_end #(
    parameter int WIDTH = 8,
    parameter int WORDS = 4
) (
    // Link pins
    input  wire logic             configClockOut,
    input  wire logic [WIDTH-1:0] cfgData,
    input  wire logic             oeWire,
    input  wire logic             doneEn,
    output logic                  loadComplete,
    // Captured words
    output logic      [WIDTH-1:0] got [WORDS]
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;

    // Capture on rising clock, start over while enable is low
    always @(posedge configClockOut or negedge oeWire) begin
        if (!oeWire) cnt <= 0;
        else begin
            if (cnt < WORDS) got[cnt] <= cfgData;
            cnt <= cnt + 1;
        end
    end

    // Completion only after exactly the full image
    assign loadComplete = doneEn && (cnt == WORDS);
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WORDS = 32;
    logic       clk, rst, imgWrEn, extClk, useExt, porLong, farLow, doneEn;
    logic [4:0] imgWrAddr;
    logic [7:0] imgWrData, cfgData;
    logic       oeOut, oeOutEn, configClockOut, cfgDataOutEn, loadDone, loadComplete;
    logic [7:0] got [WORDS];
    wire        oeWire;
    int         errTotal, nChecks;

    // Open-drain enable wire with pull-up
    assign oeWire = !(oeOutEn || farLow);

    cso_stream_out #(.WORDS(WORDS), .POR_SHORT_CNT(40), .POR_LONG_CNT(80)) cso_stream_out_i (
        .clk(clk), .rst(rst), .imgWrEn(imgWrEn), .imgWrAddr(imgWrAddr), .imgWrData(imgWrData),
        .oeIn(oeWire), .fpgaLoadComplete(loadComplete), .externalClockInput(extClk),
        .useExternalClock(useExt), .porLongSel(porLong), .oeOut(oeOut), .oeOutEn(oeOutEn),
        .configClockOut(configClockOut), .cfgData(cfgData), .cfgDataOutEn(cfgDataOutEn),
        .loadDone(loadDone)
    );

    cso_far_end #(.WIDTH(8), .WORDS(WORDS)) cso_far_end_i (
        .configClockOut(configClockOut), .cfgData(cfgData), .oeWire(oeWire),
        .doneEn(doneEn), .loadComplete(loadComplete), .got(got)
    );

    // Core clock
    always #2 clk = ~clk;

    // external source, 48 ns period, free phase
    initial begin
        extClk = 1'b0;
        #7;
        forever #24 extClk = ~extClk;
    end

    function automatic logic [7:0] img(input int i);
        return 8'(i) * 8'h1D + 8'h07;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (errTotal == 0 && nChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic do_reset(input logic ext, input logic lng);
        @(negedge clk);
        rst = 1'b1;
        // far side restarts along with us
        farLow = 1'b1;
        useExt = ext;
        porLong = lng;
        repeat (5) @(negedge clk);
        check(cfgDataOutEn, 8'h00);
        check(configClockOut, 8'h00);
        farLow = 1'b0;
        rst = 1'b0;
    endtask

    task automatic load_image;
        for (int i = 0; i < WORDS; i++) begin
            imgWrEn = 1'b1;
            imgWrAddr = 5'(i);
            imgWrData = img(i);
            @(negedge clk);
        end
        imgWrEn = 1'b0;
    endtask

    // far side holds enable low well past the reset minimum
    task automatic pull_oe(input int n);
        farLow = 1'b1;
        repeat (n) @(negedge clk);
        farLow = 1'b0;
    endtask

    task automatic run_stream(input int minCyc);
        int n;
        n = 0;
        while (cfgDataOutEn !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check(8'(n >= minCyc && n < 400), 8'h01);
        n = 0;
        while (loadDone !== 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        check(loadDone, 8'h01);
        for (int i = 0; i < WORDS; i++) check(got[i], img(i));
        check(configClockOut, 8'h00);
        check(cfgData, 8'hFF);
    endtask

    task automatic t_normal;
        do_reset(1'b0, 1'b0);
        load_image();
        run_stream(18);
    endtask

    task automatic t_crc;
        pull_oe(100);
        check(loadDone, 8'h00);
        repeat (5) @(posedge configClockOut);
        @(negedge clk);
        farLow = 1'b1;
        repeat (60) @(negedge clk);
        check(cfgDataOutEn, 8'h01);
        repeat (40) @(negedge clk);
        check(cfgDataOutEn, 8'h00);
        check(configClockOut, 8'h00);
        farLow = 1'b0;
        run_stream(10);
    endtask

    task automatic t_missing;
        int n;
        doneEn = 1'b0;
        pull_oe(100);
        n = 0;
        while (oeOutEn !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        check(oeOut, 8'h00);
        n = 0;
        while (oeOutEn === 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check(8'(n), 8'h0F);
        doneEn = 1'b1;
        run_stream(10);
    endtask

    task automatic t_ext;
        do_reset(1'b1, 1'b1);
        load_image();
        run_stream(58);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        imgWrEn = 1'b0;
        imgWrAddr = 5'h00;
        imgWrData = 8'h00;
        useExt = 1'b0;
        porLong = 1'b0;
        farLow = 1'b0;
        doneEn = 1'b1;
        errTotal = 0;
        nChecks = 0;
        t_normal();
        t_crc();
        t_missing();
        t_ext();
        tally_and_finish();
    end

    // Watchdog
    initial begin
        #100_000;
        errTotal++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
